// file: src/async_timer_map.vh
// Register map, field positions and reset values of the async timer.
// Assumes a byte-wide register port with a 4-bit register index.
`ifndef ASYNC_TIMER_MAP_VH
`define ASYNC_TIMER_MAP_VH

// Register indices on the plain register port
`define ADDR_COUNTER      4'h0
`define ADDR_COMPARE_A    4'h1
`define ADDR_COMPARE_B    4'h2
`define ADDR_CONTROL_A    4'h3
`define ADDR_CONTROL_B    4'h4
`define ADDR_ASYNC_STATUS 4'h5
`define ADDR_IRQ_MASK     4'h6
`define ADDR_IRQ_FLAGS    4'h7
`define ADDR_GEN_CONTROL  4'h8

// Async status fields
`define BIT_EXT_CLK_EN    6
`define BIT_ASYNC_SEL     5
`define BIT_CNT_PEND      4
`define BIT_CMPA_PEND     3
`define BIT_CMPB_PEND     2
`define BIT_CTLA_PEND     1
`define BIT_CTLB_PEND     0

// Interrupt enable and flag fields
`define BIT_CMPB          2
`define BIT_CMPA          1
`define BIT_OVF           0

// General timer control fields
`define BIT_SYNC_HOLD     7
`define BIT_ASYNC_PSR     1
`define BIT_SHARED_PSR    0

// Control register fields
`define CTLA_COMA_HI      7
`define CTLA_COMA_LO      6
`define CTLA_COMB_HI      5
`define CTLA_COMB_LO      4
`define CTLA_WAVE_HI      1
`define CTLA_WAVE_LO      0
`define CTLB_WAVE_BIT     3
`define CTLB_CS_HI        2
`define CTLB_CS_LO        0

// Counter landmarks and reset values
`define CNT_MAX           8'hff
`define CNT_BOTTOM        8'h00
`define RESET_BYTE        8'h00

`endif

// file: src/async_timer_register_control.v
// Register side of an 8-bit timer with I/O or oscillator-pin clocking.
// Assumes a one-cycle register port on core_clk_i and a timer oscillator
// pin that is asynchronous to it; the interrupt controller acks flags.
//
// What this block does
// [RULE1] Counter read/write; write blocks next match
// [RULE2] Both compare values always compared, drive outputs
// [RULE3] External clock buffer on when enabled and async
// [RULE4] Software sets clock enable before async select
// [RULE5] Select chooses I/O clock or oscillator pin
// [RULE6] Software rewrites registers after select change
// [RULE7] Async writes set busy until transfer done
// [RULE8] Software avoids writing while busy set
// [RULE9] Counter reads live; compare and control registers read staging
// [RULE10] Request needs enable, global bit and flag
// [RULE11] Compare equality sets compare flag
// [RULE12] Flags clear on vector or write one
// [RULE13] Overflow flag at MAX wrap (TOP in mode 7), phase PWM at bottom
// [RULE14] Hold keeps prescaler resets; release clears
// [RULE15] Async prescaler reset held until done
// [RULE16] Shared prescaler reset clears unless hold
// [RULE17] Transfer on base tick (oscillator tick when async), then busy clears
// [RULE18] Per-source acknowledge clears matching flag
`include "async_timer_map.vh"
`default_nettype none

module async_timer_register_control #(
    parameter PSC_WIDTH = 10
) (
    // Clock and reset
    input  wire       core_clk_i,
    input  wire       rstn_i,
    // Register port
    input  wire [3:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    // Interrupts
    input  wire       global_irq_en_i,
    input  wire [2:0] irq_ack_i,
    output wire [2:0] irq_req_o,
    output wire       irq_o,
    // Timer oscillator and clock controls
    input  wire       timer_osc_pin_i,
    output wire       ext_clk_buf_en_o,
    output wire       crystal_osc_en_o,
    output wire       shared_prescaler_reset_o,
    // Waveform outputs
    output reg        wave_out_a_o,
    output reg        wave_out_b_o
);

    // Prescaler tap masks for clock selects 1 to 7
    function [PSC_WIDTH-1:0] tap_mask;
        input [2:0] cs;
        begin
            case (cs)
                3'h2:    tap_mask = 'h7;
                3'h3:    tap_mask = 'h1f;
                3'h4:    tap_mask = 'h3f;
                3'h5:    tap_mask = 'h7f;
                3'h6:    tap_mask = 'hff;
                3'h7:    tap_mask = 'h3ff;
                default: tap_mask = 'h0;
            endcase
        end
    endfunction

    // Next waveform level from compare output mode and events
    function wave_next;
        input       cur;
        input [1:0] com;
        input       pwm_fast;
        input       pwm_phase;
        input       match;
        input       bottom;
        input       up;
        begin
            wave_next = cur;
            if (pwm_fast) begin
                if (com[1] && match)
                    wave_next = com[0];
                else if (com[1] && bottom)
                    wave_next = ~com[0];
            end else if (pwm_phase) begin
                if (com[1] && match)
                    wave_next = up ? com[0] : ~com[0];
            end else if (match) begin
                case (com)
                    2'h1:    wave_next = ~cur;
                    2'h2:    wave_next = 1'b0;
                    2'h3:    wave_next = 1'b1;
                    default: wave_next = cur;
                endcase
            end
        end
    endfunction

    // Staged (temporary) and active copies of the five registers
    reg [7:0] cnt_tmp_reg;
    reg [7:0] cmpa_tmp_reg;
    reg [7:0] cmpb_tmp_reg;
    reg [7:0] ctla_tmp_reg;
    reg [7:0] ctlb_tmp_reg;
    reg [7:0] counter_reg;
    reg [7:0] cmpa_reg;
    reg [7:0] cmpb_reg;
    reg [7:0] ctla_reg;
    reg [7:0] ctlb_reg;
    wire [4:0] pend_reg;
    reg       ext_en_reg;
    reg       async_sel_reg;
    reg [2:0] mask_reg;
    reg [2:0] flag_reg;
    reg       hold_reg;
    reg       async_psr_reg;
    reg       shared_psr_reg;
    reg       up_reg;
    reg       block_reg;
    reg [PSC_WIDTH-1:0] psc_reg;
    reg       osc_meta_reg;
    reg       osc_sync_reg;
    reg       osc_prev_reg;

    // Decoded write strobes
    wire wr_cnt  = wr_i && (addr_i == `ADDR_COUNTER);
    wire wr_cmpa = wr_i && (addr_i == `ADDR_COMPARE_A);
    wire wr_cmpb = wr_i && (addr_i == `ADDR_COMPARE_B);
    wire wr_ctla = wr_i && (addr_i == `ADDR_CONTROL_A);
    wire wr_ctlb = wr_i && (addr_i == `ADDR_CONTROL_B);
    wire wr_asr  = wr_i && (addr_i == `ADDR_ASYNC_STATUS);
    wire wr_mask = wr_i && (addr_i == `ADDR_IRQ_MASK);
    wire wr_flag = wr_i && (addr_i == `ADDR_IRQ_FLAGS);
    wire wr_gtc  = wr_i && (addr_i == `ADDR_GEN_CONTROL);
    wire [4:0] wr_stage = {wr_cnt, wr_cmpa, wr_cmpb, wr_ctla, wr_ctlb};

    // Oscillator pin: two-flop synchroniser, then edge detect
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_meta_reg <= timer_osc_pin_i;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    wire osc_tick  = osc_sync_reg && !osc_prev_reg;
    // Base clock: every I/O cycle or each rising oscillator edge
    wire base_tick = async_sel_reg ? osc_tick : 1'b1; // [RULE5]
    // Staged copy moves into the active register on this event
    wire xfer      = base_tick; // [RULE17]

    // Clock pin controls
    assign ext_clk_buf_en_o = ext_en_reg && async_sel_reg; // [RULE3]
    assign crystal_osc_en_o = async_sel_reg && !ext_en_reg; // [RULE3]

    // Prescaler and timer clock enable
    wire [2:0]           cs   = ctlb_reg[`CTLB_CS_HI:`CTLB_CS_LO];
    wire [PSC_WIDTH-1:0] tmsk = tap_mask(cs);
    wire timer_tick = base_tick && !async_psr_reg && (cs != 3'h0) &&
                      ((psc_reg & tmsk) == tmsk);

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            psc_reg <= {PSC_WIDTH{1'b0}};
        else if (async_psr_reg)
            psc_reg <= {PSC_WIDTH{1'b0}}; // [RULE15]
        else if (base_tick)
            psc_reg <= psc_reg + 1'b1;
    end

    // Waveform mode decode
    wire [2:0] wgm = {ctlb_reg[`CTLB_WAVE_BIT],
                      ctla_reg[`CTLA_WAVE_HI:`CTLA_WAVE_LO]};
    wire pwm_phase = (wgm[1:0] == 2'h1);
    wire pwm_fast  = (wgm[1:0] == 2'h3);
    wire [7:0] top = (wgm[2] || wgm == 3'h2) ? cmpa_reg : `CNT_MAX;
    wire at_top    = (counter_reg == top);
    wire at_bottom = (counter_reg == `CNT_BOTTOM);

    // Compare matches, suppressed after a counter write
    wire match_a = timer_tick && !block_reg &&
                   (counter_reg == cmpa_reg); // [RULE2] [RULE1]
    wire match_b = timer_tick && !block_reg &&
                   (counter_reg == cmpb_reg); // [RULE2] [RULE1]
    // Overflow: wrap at MAX (TOP in mode 7), bottom turn in phase PWM
    wire ovf_ev  = timer_tick && (pwm_phase ?
                   (at_bottom && !up_reg) :
                   (at_top && (wgm == 3'h7 || top == `CNT_MAX))); // [RULE13]
    wire wrap_ev = timer_tick && !pwm_phase && at_top;

    // Staging registers take software writes at once
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_tmp_reg  <= `RESET_BYTE;
            cmpa_tmp_reg <= `RESET_BYTE;
            cmpb_tmp_reg <= `RESET_BYTE;
            ctla_tmp_reg <= `RESET_BYTE;
            ctlb_tmp_reg <= `RESET_BYTE;
        end else begin
            if (wr_cnt)
                cnt_tmp_reg <= wdata_i;
            if (wr_cmpa)
                cmpa_tmp_reg <= wdata_i;
            if (wr_cmpb)
                cmpb_tmp_reg <= wdata_i;
            if (wr_ctla)
                ctla_tmp_reg <= wdata_i;
            if (wr_ctlb)
                ctlb_tmp_reg <= {4'h0, wdata_i[3:0]};
        end
    end

    // Update-pending flags; a write in the transfer cycle keeps it set
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_pend
            reg pend_bit_reg;
            always @(posedge core_clk_i or negedge rstn_i) begin
                if (!rstn_i)
                    pend_bit_reg <= 1'b0;
                else if (wr_stage[gi])
                    pend_bit_reg <= 1'b1; // [RULE7]
                else if (xfer)
                    pend_bit_reg <= 1'b0; // [RULE7] [RULE17]
            end
            assign pend_reg[gi] = pend_bit_reg;
        end
    endgenerate

    // Active compare and control values load from staging
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmpa_reg <= `RESET_BYTE;
            cmpb_reg <= `RESET_BYTE;
            ctla_reg <= `RESET_BYTE;
            ctlb_reg <= `RESET_BYTE;
        end else if (xfer) begin
            if (pend_reg[`BIT_CMPA_PEND])
                cmpa_reg <= cmpa_tmp_reg; // [RULE17]
            if (pend_reg[`BIT_CMPB_PEND])
                cmpb_reg <= cmpb_tmp_reg;
            if (pend_reg[`BIT_CTLA_PEND])
                ctla_reg <= ctla_tmp_reg;
            if (pend_reg[`BIT_CTLB_PEND])
                ctlb_reg <= ctlb_tmp_reg;
        end
    end

    // Compare blocking after a counter load
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            block_reg    <= 1'b0;
        end else begin
            if (xfer && pend_reg[`BIT_CNT_PEND])
                block_reg <= 1'b1; // [RULE1]
            else if (timer_tick)
                block_reg <= 1'b0; // [RULE1]
        end
    end

    // Counter and count direction
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            counter_reg <= `CNT_BOTTOM;
            up_reg      <= 1'b1;
        end else if (xfer && pend_reg[`BIT_CNT_PEND]) begin
            counter_reg <= cnt_tmp_reg; // [RULE1]
        end else if (timer_tick) begin
            if (!pwm_phase) begin
                up_reg      <= 1'b1;
                counter_reg <= at_top ? `CNT_BOTTOM : counter_reg + 8'h01;
            end else if (up_reg) begin
                if (at_top) begin
                    up_reg      <= 1'b0;
                    counter_reg <= counter_reg - 8'h01;
                end else begin
                    counter_reg <= counter_reg + 8'h01;
                end
            end else if (at_bottom) begin
                up_reg      <= 1'b1;
                counter_reg <= counter_reg + 8'h01;
            end else begin
                counter_reg <= counter_reg - 8'h01;
            end
        end
    end

    // Waveform outputs
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wave_out_a_o <= 1'b0;
            wave_out_b_o <= 1'b0;
        end else begin
            wave_out_a_o <= wave_next(wave_out_a_o,
                ctla_reg[`CTLA_COMA_HI:`CTLA_COMA_LO], pwm_fast,
                pwm_phase, match_a, wrap_ev, up_reg); // [RULE2]
            wave_out_b_o <= wave_next(wave_out_b_o,
                ctla_reg[`CTLA_COMB_HI:`CTLA_COMB_LO], pwm_fast,
                pwm_phase, match_b, wrap_ev, up_reg); // [RULE2]
        end
    end

    // Interrupt flags: set wins over write-one and acknowledge clears
    wire [2:0] flag_set = {match_b, match_a, ovf_ev}; // [RULE11] [RULE13]
    wire [2:0] flag_clr = (wr_flag ? wdata_i[2:0] : 3'h0) |
                          irq_ack_i; // [RULE12] [RULE18]

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            flag_reg <= 3'h0;
        else
            flag_reg <= flag_set | (flag_reg & ~flag_clr); // [RULE12]
    end

    // Interrupt requests
    assign irq_req_o = flag_reg & mask_reg &
                       {3{global_irq_en_i}}; // [RULE10]
    assign irq_o     = |irq_req_o;

    // Async status and interrupt mask registers
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_en_reg    <= 1'b0;
            async_sel_reg <= 1'b0;
            mask_reg      <= 3'h0;
        end else begin
            if (wr_asr) begin
                ext_en_reg    <= wdata_i[`BIT_EXT_CLK_EN];
                async_sel_reg <= wdata_i[`BIT_ASYNC_SEL]; // [RULE5]
            end
            if (wr_mask)
                mask_reg <= wdata_i[2:0];
        end
    end

    // Prescaler reset bits and synchronization hold
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_reg       <= 1'b0;
            async_psr_reg  <= 1'b0;
            shared_psr_reg <= 1'b0;
        end else if (wr_gtc) begin
            hold_reg <= wdata_i[`BIT_SYNC_HOLD];
            if (!wdata_i[`BIT_SYNC_HOLD]) begin
                // Hold off or released: shared reset lasts one cycle, async reset until a base tick
                async_psr_reg  <= wdata_i[`BIT_ASYNC_PSR] ||
                                  (async_psr_reg && !hold_reg); // [RULE14]
                shared_psr_reg <= wdata_i[`BIT_SHARED_PSR]; // [RULE14]
            end else begin
                async_psr_reg  <= async_psr_reg |
                                  wdata_i[`BIT_ASYNC_PSR]; // [RULE14]
                shared_psr_reg <= shared_psr_reg |
                                  wdata_i[`BIT_SHARED_PSR]; // [RULE14]
            end
        end else if (!hold_reg) begin
            shared_psr_reg <= 1'b0; // [RULE16]
            if (!async_sel_reg || base_tick)
                async_psr_reg <= 1'b0; // [RULE15]
        end
    end

    assign shared_prescaler_reset_o = shared_psr_reg; // [RULE16]

    // Read data, one cycle after the read strobe
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            rdata_o <= 8'h00;
        else if (!rd_i)
            rdata_o <= 8'h00;
        else if (addr_i == `ADDR_COUNTER)
            rdata_o <= counter_reg; // [RULE9]
        else if (addr_i == `ADDR_COMPARE_A)
            rdata_o <= cmpa_tmp_reg; // [RULE9]
        else if (addr_i == `ADDR_COMPARE_B)
            rdata_o <= cmpb_tmp_reg; // [RULE9]
        else if (addr_i == `ADDR_CONTROL_A)
            rdata_o <= {ctla_tmp_reg[7:4], 2'h0, ctla_tmp_reg[1:0]};
        else if (addr_i == `ADDR_CONTROL_B)
            rdata_o <= {4'h0, ctlb_tmp_reg[3:0]};
        else if (addr_i == `ADDR_ASYNC_STATUS)
            rdata_o <= {1'b0, ext_en_reg, async_sel_reg, pend_reg};
        else if (addr_i == `ADDR_IRQ_MASK)
            rdata_o <= {5'h00, mask_reg};
        else if (addr_i == `ADDR_IRQ_FLAGS)
            rdata_o <= {5'h00, flag_reg};
        else if (addr_i == `ADDR_GEN_CONTROL)
            rdata_o <= {hold_reg, 5'h00, async_psr_reg, shared_psr_reg};
        else
            rdata_o <= 8'h00;
    end

endmodule // async_timer_register_control

`default_nettype wire

// file: bench/async_timer_props_properties.sv
// Port-level checker for the async timer register block.
// Assumes one clock domain on core_clk_i and an active-low async reset.
`include "async_timer_map.vh"
`default_nettype none

module async_timer_props #(
    parameter PSC_WIDTH = 10
) (
    // Clock and reset
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    // Interrupts
    input wire logic       global_irq_en_i,
    input wire logic [2:0] irq_ack_i,
    input wire logic [2:0] irq_req_o,
    input wire logic       irq_o,
    // Oscillator and prescaler controls
    input wire logic       timer_osc_pin_i,
    input wire logic       ext_clk_buf_en_o,
    input wire logic       crystal_osc_en_o,
    input wire logic       shared_prescaler_reset_o,
    // Waveform outputs
    input wire logic       wave_out_a_o,
    input wire logic       wave_out_b_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic hold_q;
    wire  psr_wr = wr_i && (addr_i == `ADDR_GEN_CONTROL);
    wire  osc_wr = wr_i && (addr_i == `ADDR_ASYNC_STATUS);

    // Shadow of the hold bit, as last written by software
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_q <= 1'b0;
        end else if (psr_wr) begin
            hold_q <= wdata_i[`BIT_SYNC_HOLD];
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_irq_is_or: assert property (irq_o == |irq_req_o)
        else $error("irq_o differs from OR of requests");
    a_req_needs_global: assert property
        (!global_irq_en_i |-> irq_req_o == 3'b000)
        else $error("request without global enable");
    a_read_idle_zero: assert property
        (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    a_osc_enable_follow: assert property (osc_wr |=>
        ext_clk_buf_en_o == $past(wdata_i[6] & wdata_i[5]) &&
        crystal_osc_en_o == $past(wdata_i[5] & ~wdata_i[6]))
        else $error("oscillator enables do not follow write");
    a_osc_never_both: assert property
        (!(ext_clk_buf_en_o && crystal_osc_en_o))
        else $error("buffer and crystal enabled together");
    a_shared_psr_set: assert property
        (psr_wr && wdata_i[0] |=> shared_prescaler_reset_o)
        else $error("shared prescaler reset not set by write");
    a_shared_psr_clear: assert property
        (shared_prescaler_reset_o && !hold_q && !psr_wr |=>
        !shared_prescaler_reset_o)
        else $error("shared prescaler reset not cleared");
    a_hold_keeps_psr: assert property
        (shared_prescaler_reset_o && hold_q && !psr_wr |=>
        shared_prescaler_reset_o)
        else $error("prescaler reset dropped during hold");
    a_hold_release: assert property
        (psr_wr && !wdata_i[7] && !wdata_i[0] |=> !shared_prescaler_reset_o)
        else $error("release did not clear prescaler reset");
    a_irq_fall_cause: assert property ($fell(irq_o) |->
        !global_irq_en_i || $past(wr_i) || $past(|irq_ack_i))
        else $error("interrupt dropped without clear");

    // Main scenarios reached
    c_irq_rise: cover property ($rose(irq_o));
    c_hold_held: cover property (hold_q && shared_prescaler_reset_o);
    c_ext_clock: cover property (ext_clk_buf_en_o);
endmodule // async_timer_props

bind async_timer_register_control async_timer_props #(
    .PSC_WIDTH(PSC_WIDTH)
) i_async_timer_props (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .global_irq_en_i(global_irq_en_i), .irq_ack_i(irq_ack_i),
    .irq_req_o(irq_req_o), .irq_o(irq_o),
    .timer_osc_pin_i(timer_osc_pin_i),
    .ext_clk_buf_en_o(ext_clk_buf_en_o),
    .crystal_osc_en_o(crystal_osc_en_o),
    .shared_prescaler_reset_o(shared_prescaler_reset_o),
    .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o)
);

`default_nettype wire

// file: bench/async_timer_register_control_tb.sv
// Self-checking bench for the async timer register block.
// Assumes the register map header and a 250 MHz core clock.
`include "async_timer_map.vh"
`default_nettype none

module async_timer_register_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       core_clk_i, rstn_i, wr_i, rd_i, global_irq_en_i;
    logic       timer_osc_pin_i, irq_o, wave_out_a_o, wave_out_b_o;
    logic       ext_clk_buf_en_o, crystal_osc_en_o, shared_prescaler_reset_o;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic [2:0] irq_ack_i, irq_req_o;
    int         bad_count, compares;

    async_timer_register_control i_async_timer_register_control (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .global_irq_en_i(global_irq_en_i), .irq_ack_i(irq_ack_i),
        .irq_req_o(irq_req_o), .irq_o(irq_o),
        .timer_osc_pin_i(timer_osc_pin_i),
        .ext_clk_buf_en_o(ext_clk_buf_en_o),
        .crystal_osc_en_o(crystal_osc_en_o),
        .shared_prescaler_reset_o(shared_prescaler_reset_o),
        .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o)
    );

    // Core clock, 4 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    // Compare and count
    task automatic chk(input logic [7:0] seen, exp, input string what);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge core_clk_i);
        wr_i    <= 1'b0;
        #1;
    endtask

    // Read, masked compare of the answer cycle
    task automatic rchk(input logic [3:0] a, input logic [7:0] m, exp,
                        input string what);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o & m, exp, what);
    endtask

    // Run the timer at full rate for a while, then stop it
    task automatic run(input logic [7:0] start);
        wr(`ADDR_COUNTER, start);
        wr(`ADDR_CONTROL_B, 8'h01);
        repeat (4) @(posedge core_clk_i);
        wr(`ADDR_CONTROL_B, 8'h00);
        repeat (4) @(posedge core_clk_i);
    endtask

    // One acknowledge pulse
    task automatic ack(input logic [2:0] which);
        @(posedge core_clk_i);
        irq_ack_i <= which;
        @(posedge core_clk_i);
        irq_ack_i <= 3'b000;
        #1;
    endtask

    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #100000;
        $display("timeout reached");
        bad_count++;
        close_out();
    end

    // Main sequence
    initial begin
        bad_count = 0;
        compares = 0;
        rstn_i = 1'b0;
        {wr_i, rd_i, timer_osc_pin_i} = 3'b000;
        global_irq_en_i = 1'b1;
        irq_ack_i = 3'b000;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        repeat (12) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        // Reset values, unmapped index, mask width
        for (int i = 0; i < 9; i++) begin
            rchk(i[3:0], 8'hff, `RESET_BYTE, "reset value");
        end
        wr(4'hf, 8'hff);
        rchk(4'hf, 8'hff, 8'h00, "unmapped");
        wr(`ADDR_IRQ_MASK, 8'hff);
        rchk(`ADDR_IRQ_MASK, 8'hff, 8'h07, "mask width");
        $display("test reset done");
        // Clock source enables; buffer enable before async select
        wr(`ADDR_ASYNC_STATUS, 8'h20);
        chk({7'h0, crystal_osc_en_o}, 8'h01, "crystal on");
        chk({7'h0, ext_clk_buf_en_o}, 8'h00, "buffer off");
        wr(`ADDR_ASYNC_STATUS, 8'h00);
        wr(`ADDR_ASYNC_STATUS, 8'h40);
        chk({7'h0, ext_clk_buf_en_o}, 8'h00, "buffer sync");
        wr(`ADDR_ASYNC_STATUS, 8'h60);
        chk({7'h0, crystal_osc_en_o}, 8'h00, "crystal off");
        chk({7'h0, ext_clk_buf_en_o}, 8'h01, "buffer on");
        // Async staging: each written once, busy until an oscillator edge
        wr(`ADDR_COUNTER, 8'h11);
        wr(`ADDR_COMPARE_A, 8'h22);
        wr(`ADDR_COMPARE_B, 8'h33);
        wr(`ADDR_CONTROL_A, 8'h02);
        wr(`ADDR_CONTROL_B, 8'h00);
        rchk(`ADDR_ASYNC_STATUS, 8'hff, 8'h7f, "all busy");
        rchk(`ADDR_COUNTER, 8'hff, 8'h00, "live counter");
        rchk(`ADDR_COMPARE_A, 8'hff, 8'h22, "staged cmp a");
        rchk(`ADDR_COMPARE_B, 8'hff, 8'h33, "staged cmp b");
        rchk(`ADDR_CONTROL_A, 8'hff, 8'h02, "staged ctl a");
        timer_osc_pin_i <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        timer_osc_pin_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        rchk(`ADDR_ASYNC_STATUS, 8'hff, 8'h60, "busy cleared");
        rchk(`ADDR_COUNTER, 8'hff, 8'h11, "counter loaded");
        wr(`ADDR_ASYNC_STATUS, 8'h00);
        $display("test async staging done");
        // All five rewritten after the select change; A and B toggle
        wr(`ADDR_CONTROL_A, 8'h50);
        wr(`ADDR_COMPARE_A, 8'h40);
        wr(`ADDR_COMPARE_B, 8'h42);
        wr(`ADDR_IRQ_FLAGS, 8'h07);
        run(8'h40);
        rchk(`ADDR_IRQ_FLAGS, 8'h06, 8'h04, "blocked match");
        chk({7'h0, wave_out_a_o}, 8'h00, "no toggle");
        chk({7'h0, wave_out_b_o}, 8'h01, "toggle b");
        run(8'h3e);
        rchk(`ADDR_IRQ_FLAGS, 8'h06, 8'h06, "both matches");
        chk({7'h0, wave_out_a_o}, 8'h01, "toggled");
        chk({7'h0, wave_out_b_o}, 8'h00, "toggle b back");
        // Request gating and clearing
        chk({5'h0, irq_req_o}, 8'h06, "requests");
        chk({7'h0, irq_o}, 8'h01, "irq on");
        @(posedge core_clk_i);
        global_irq_en_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk({7'h0, irq_o}, 8'h00, "global off");
        @(posedge core_clk_i);
        global_irq_en_i <= 1'b1;
        wr(`ADDR_IRQ_MASK, 8'h02);
        chk({5'h0, irq_req_o}, 8'h02, "masked");
        wr(`ADDR_IRQ_FLAGS, 8'h00);
        rchk(`ADDR_IRQ_FLAGS, 8'hff, 8'h06, "zero write");
        wr(`ADDR_IRQ_FLAGS, 8'h02);
        rchk(`ADDR_IRQ_FLAGS, 8'hff, 8'h04, "one clears");
        ack(3'b100);
        rchk(`ADDR_IRQ_FLAGS, 8'hff, 8'h00, "ack b");
        // Overflow at wrap
        run(8'hfd);
        rchk(`ADDR_IRQ_FLAGS, 8'h01, 8'h01, "overflow");
        ack(3'b001);
        rchk(`ADDR_IRQ_FLAGS, 8'h01, 8'h00, "ack ovf");
        $display("test compare and interrupts done");
        // Prescaler resets under hold, then release
        wr(`ADDR_GEN_CONTROL, 8'h83);
        repeat (3) @(posedge core_clk_i);
        chk({7'h0, shared_prescaler_reset_o}, 8'h01, "held");
        rchk(`ADDR_GEN_CONTROL, 8'hff, 8'h83, "hold kept");
        wr(`ADDR_GEN_CONTROL, 8'h00);
        rchk(`ADDR_GEN_CONTROL, 8'hff, 8'h00, "released");
        wr(`ADDR_GEN_CONTROL, 8'h03);
        repeat (2) @(posedge core_clk_i);
        rchk(`ADDR_GEN_CONTROL, 8'hff, 8'h00, "self clear");
        $display("test prescaler done");
        close_out();
    end
endmodule // async_timer_register_control_tb

`default_nettype wire
